// ### pkg/alu_exec_regs.vh
// Opcode codes, flag positions and cycle counts of the execution datapath
`ifndef ALU_EXEC_REGS_VH
`define ALU_EXEC_REGS_VH
// Operation codes presented by the decoder
`define OP_ADD 5'h00
`define OP_ADD_CARRY 5'h01
`define OP_WORD_IMMEDIATE_ADD 5'h02
`define OP_SUB 5'h03
`define OP_CONSTANT_SUBTRACT 5'h04
`define OP_BORROW_SUBTRACT 5'h05
`define OP_BORROW_CONST_SUBTRACT 5'h06
`define OP_WORD_IMMEDIATE_SUBTRACT 5'h07
`define OP_AND 5'h08
`define OP_AND_CONST 5'h09
`define OP_OR 5'h0a
`define OP_OR_CONST 5'h0b
`define OP_EXCLUSIVE_OR 5'h0c
`define OP_BIT_SET_MASK 5'h0d
`define OP_BIT_CLEAR_MASK 5'h0e
`define OP_SELF_AND_PROBE 5'h0f
`define OP_UNSIGNED_PRODUCT 5'h10
`define OP_SIGNED_PRODUCT 5'h11
`define OP_MIXED_SIGN_PRODUCT 5'h12
`define OP_FRACTION_UNSIGNED_PRODUCT 5'h13
`define OP_FRACTION_SIGNED_PRODUCT 5'h14
`define OP_FRACTION_MIXED_PRODUCT 5'h15
`define OP_RELATIVE_JUMP 5'h16
`define OP_POINTER_JUMP 5'h17
`define OP_RELATIVE_CALL 5'h18
`define OP_POINTER_CALL 5'h19
`define OP_COMPARE_SKIP_EQUAL 5'h1a
// Status flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
// Reset values
`define FLAGS_RESET 6'h00
`define PC_RESET 16'h0000
// Cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
// Mask complement constant
`define BYTE_ALL_ONES 8'hff
`endif

// ### testbench/cpu_alu_branch_exec_test.sv
// Self-checking bench for the execution datapath
`include "alu_exec_regs.vh"
module cpu_alu_branch_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Signals
   logic mclk = 0, rst_b = 0, clk_en = 1, op_start = 0, next_is_two_word = 0;
   logic [4:0] op_code = 0;
   logic [7:0] rd_val = 0, rr_val = 0, rd_hi_val = 0, imm_val = 0, rd_res_q, rd_hi_res_q;
   logic [11:0] rel_offset = 0;
   logic [15:0] z_ptr = 0, pc_in, pc_q, push_addr_q, prod_q, stack_top;
   logic pc_load_q, push_q, rd_we_q, rd_hi_we_q, prod_we_q, busy, done_q;
   logic [5:0] flags_q, f;
   int n_errors = 0, n_tests = 0, cyc, cycles = 0, i;
   cpu_alu_branch_exec cpu_alu_branch_exec_i (.*);
   exec_partner exec_partner_i (.*);
   initial forever #50 mclk = ~mclk;
   // Cut a hang short well past the hundred or so cycles needed
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ==========
   // Shared tasks
   task chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, m);
      end
   endtask
   // Issue one op, then wait for done; w feeds the Z pair, offset, high byte and skip size
   task run(input logic [4:0] op, input logic [7:0] a, b, k, input logic [15:0] w);
      @(posedge mclk);
      op_code <= op;
      rd_val <= a;
      rr_val <= b;
      imm_val <= k;
      z_ptr <= w;
      rel_offset <= w[11:0];
      rd_hi_val <= w[15:8];
      next_is_two_word <= w[0];
      op_start <= 1'b1;
      cyc = 0;
      do begin
         @(posedge mclk);
         op_start <= 1'b0;
         #1;
         cyc++;
      end while (done_q !== 1'b1 && cyc < 8);
   endtask
   task res(input logic [7:0] r, input logic [5:0] m, v, input int c);
      chk(rd_res_q === r && (flags_q & m) === v && cyc == c && pc_load_q === 1'b0,
         "result, flags, cycles or stray PC load");
   endtask
   task pcs(input logic [15:0] p, input int c);
      chk(pc_q === p && pc_load_q === 1'b1 && cyc == c, "program counter or cycles");
   endtask
   task tally_and_finish;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========
   // Scenarios
   task t_arith;
      run(`OP_ADD, 8'h0f, 8'h01, 8'h00, 16'h0000); res(8'h10, 6'h2f, 6'h20, 1);
      run(`OP_ADD, 8'hff, 8'h01, 8'h00, 16'h0000); res(8'h00, 6'h2f, 6'h23, 1);
      run(`OP_ADD_CARRY, 8'h01, 8'h01, 8'h00, 16'h0000); res(8'h03, 6'h2f, 6'h00, 1);
      run(`OP_CONSTANT_SUBTRACT, 8'h00, 8'h00, 8'h01, 16'h0000); res(8'hff, 6'h2f, 6'h25, 1);
      run(`OP_BORROW_SUBTRACT, 8'h00, 8'h01, 8'h00, 16'h0000); res(8'hfe, 6'h2f, 6'h25, 1);
      run(`OP_BORROW_CONST_SUBTRACT, 8'h05, 8'h00, 8'h01, 0); res(8'h03, 6'h2f, 6'h00, 1);
      run(`OP_SUB, 8'h10, 8'h01, 8'h00, 16'h0000); res(8'h0f, 6'h2f, 6'h20, 1);
      $display("test arith done");
   endtask
   task t_logic;
      logic [4:0] lop [8];
      logic [7:0] lex [8];
      lop = '{`OP_AND, `OP_AND_CONST, `OP_OR, `OP_OR_CONST, `OP_EXCLUSIVE_OR,
         `OP_BIT_SET_MASK, `OP_BIT_CLEAR_MASK, `OP_SELF_AND_PROBE};
      lex = '{8'h42, 8'h42, 8'hdb, 8'hdb, 8'h99, 8'hdb, 8'h81, 8'hc3};
      for (i = 0; i < 8; i++) begin
         run(lop[i], 8'hc3, 8'h5a, 8'h5a, 16'h0000);
         res(lex[i], 6'h0e, {3'h0, lex[i][7], 2'h0}, 1);
      end
      run(`OP_EXCLUSIVE_OR, 8'h5a, 8'h5a, 8'h00, 16'h0000); res(8'h00, 6'h0e, 6'h02, 1);
      $display("test logic done");
   endtask
   task t_word;
      run(`OP_WORD_IMMEDIATE_ADD, 8'hff, 8'h00, 8'h01, 16'h7f00); res(8'h00, 6'h1f, 6'h0c, 2);
      chk(rd_hi_res_q === 8'h80, "word add high byte");
      run(`OP_WORD_IMMEDIATE_SUBTRACT, 8'h00, 8'h00, 8'h01, 0); res(8'hff, 6'h1f, 6'h15, 2);
      chk(rd_hi_res_q === 8'hff, "word subtract high byte");
      $display("test word done");
   endtask
   task t_mul;
      logic [4:0] mop [6];
      logic [7:0] ma [6];
      logic [7:0] mb [6];
      logic [15:0] mex [6];
      logic mc [6];
      mop = '{`OP_UNSIGNED_PRODUCT, `OP_SIGNED_PRODUCT, `OP_MIXED_SIGN_PRODUCT,
         `OP_FRACTION_UNSIGNED_PRODUCT, `OP_FRACTION_SIGNED_PRODUCT, `OP_FRACTION_MIXED_PRODUCT};
      ma = '{8'hff, 8'hff, 8'hff, 8'h80, 8'h80, 8'hff};
      mb = '{8'hff, 8'hff, 8'h02, 8'h80, 8'h80, 8'h80};
      mex = '{16'hfe01, 16'h0001, 16'hfffe, 16'h8000, 16'h8000, 16'hff00};
      mc = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      for (i = 0; i < 6; i++) begin
         run(mop[i], ma[i], mb[i], 8'h00, 16'h0000);
         chk(prod_q === mex[i] && flags_q[1:0] === {1'b0, mc[i]} && cyc == 2, "product");
      end
      $display("test multiply done");
   endtask
   task t_flow;
      run(`OP_RELATIVE_JUMP, 8'h00, 8'h00, 8'h00, 16'h0ffe); pcs(16'h00ff, 2);
      f = flags_q;
      run(`OP_POINTER_JUMP, 8'h00, 8'h00, 8'h00, 16'h1234); pcs(16'h1234, 2);
      run(`OP_RELATIVE_CALL, 8'h00, 8'h00, 8'h00, 16'h0010); pcs(16'h1245, 3);
      chk(stack_top === 16'h1235, "relative call return address");
      run(`OP_POINTER_CALL, 8'h00, 8'h00, 8'h00, 16'h0200); pcs(16'h0200, 3);
      chk(stack_top === 16'h1246 && flags_q === f, "pointer call stack or flags");
      run(`OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 16'h0000); pcs(16'h0202, 2);
      run(`OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 16'h0001); pcs(16'h0205, 3);
      run(`OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 8'h00, 16'h0001); pcs(16'h0206, 1);
      $display("test flow done");
   endtask
   task t_hold;
      @(posedge mclk);
      op_code <= `OP_WORD_IMMEDIATE_SUBTRACT;
      rd_val <= 8'h34;
      rd_hi_val <= 8'h12;
      imm_val <= 8'h04;
      op_start <= 1'b1;
      @(posedge mclk);
      op_start <= 1'b0;
      clk_en <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk(busy === 1'b1 && done_q === 1'b0, "frozen op went on");
      @(posedge mclk);
      clk_en <= 1'b1;
      @(posedge mclk);
      #1 chk(done_q === 1'b1 && rd_res_q === 8'h30 && rd_hi_res_q === 8'h12, "after freeze");
      chk(pc_load_q === 1'b0 && flags_q[0] === 1'b0, "freeze load or carry");
      $display("test hold done");
   endtask
   task t_reset;
      run(`OP_ADD, 8'hff, 8'h01, 8'h00, 16'h0000); res(8'h00, 6'h2f, 6'h23, 1);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk(flags_q === 6'h00 && pc_q === 16'h0000 && busy === 1'b0, "reset state");
      chk(pc_in === 16'h0100 && stack_top === 16'h0000, "partner reset state");
      @(posedge mclk);
      rst_b <= 1'b1;
      run(`OP_ADD_CARRY, 8'h01, 8'h01, 8'h00, 16'h0000); res(8'h02, 6'h2f, 6'h00, 1);
      $display("test reset done");
   endtask
   // ==========
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      t_arith();
      t_logic();
      t_word();
      t_mul();
      t_flow();
      t_hold();
      t_reset();
      tally_and_finish();
   end
endmodule // cpu_alu_branch_exec_test

// ### testbench/exec_checker.sv
// Concurrent checks on the execution datapath ports
`include "alu_exec_regs.vh"
module exec_checker (
   // Clock and reset
   input logic mclk,
   input logic rst_b,
   input logic clk_en,
   // Decoder request
   input logic op_start,
   input logic [4:0] op_code,
   input logic [7:0] rd_val,
   input logic [7:0] rr_val,
   input logic [15:0] z_ptr,
   input logic [15:0] pc_in,
   // Results
   input logic [15:0] pc_q,
   input logic pc_load_q,
   input logic push_q,
   input logic [15:0] push_addr_q,
   input logic rd_we_q,
   input logic rd_hi_we_q,
   input logic [7:0] rd_res_q,
   input logic prod_we_q,
   input logic [15:0] prod_q,
   input logic [5:0] flags_q,
   input logic busy,
   input logic done_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ==========
   // Sequences: issue, two and three cycle completion
   sequence s_take(logic [4:0] c);
      clk_en && op_start && !busy && op_code == c;
   endsequence
   sequence s_two;
      busy ##1 (done_q && !busy);
   endsequence
   sequence s_three;
      busy ##1 busy ##1 (done_q && pc_load_q);
   endsequence
   // ==========
   // Properties
   AST_ADD_ONE: assert property (s_take(`OP_ADD) |=>
      done_q && rd_we_q && rd_res_q == $past(rd_val) + $past(rr_val)) else $error("add failed");
   AST_WORD_ADD: assert property (s_take(`OP_WORD_IMMEDIATE_ADD) |=> s_two ##0 !pc_load_q)
      else $error("word add timing");
   AST_XOR: assert property (s_take(`OP_EXCLUSIVE_OR) |=>
      done_q && !flags_q[`FLAG_V] && rd_res_q == ($past(rd_val) ^ $past(rr_val)))
      else $error("xor failed");
   AST_ZERO_NEG: assert property (rd_we_q && !rd_hi_we_q |->
      flags_q[`FLAG_Z] == (rd_res_q == 8'h00) && flags_q[`FLAG_N] == rd_res_q[7])
      else $error("zero or negative flag wrong");
   AST_PRODUCT: assert property (s_take(`OP_UNSIGNED_PRODUCT) |=>
      (prod_we_q && prod_q == $past(rd_val) * $past(rr_val)) ##1 done_q)
      else $error("product failed");
   AST_PTR_JUMP: assert property (s_take(`OP_POINTER_JUMP) |=>
      s_two ##0 (pc_load_q && pc_q == $past(z_ptr, 2) && $stable(flags_q)))
      else $error("pointer jump failed");
   AST_PTR_CALL: assert property (s_take(`OP_POINTER_CALL) |=>
      (push_q && push_addr_q == $past(pc_in) + 16'h0001) ##0 s_three
      ##0 (pc_q == $past(z_ptr, 3))) else $error("pointer call failed");
   AST_REL_CALL: assert property (s_take(`OP_RELATIVE_CALL) |=> push_q ##0 s_three)
      else $error("relative call timing");
   AST_SKIP_NE: assert property (s_take(`OP_COMPARE_SKIP_EQUAL) && rd_val != rr_val |=>
      done_q && pc_load_q && pc_q == $past(pc_in) + 16'h0001) else $error("skip failed");
endmodule // exec_checker

bind cpu_alu_branch_exec exec_checker exec_checker_i (.*);

// ### testbench/exec_partner.sv
// Program counter and return stack model facing the datapath
module exec_partner #(parameter logic [15:0] START_PC = 16'h0100) (
   // Clock and reset
   input logic mclk,
   input logic rst_b,
   // From the datapath
   input logic pc_load_q,
   input logic [15:0] pc_q,
   input logic push_q,
   input logic [15:0] push_addr_q,
   // To the datapath and bench
   output logic [15:0] pc_in,
   output logic [15:0] stack_top
);
   // PC moves only on a load, so it stays still while an op runs
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pc_in <= START_PC;
         stack_top <= 16'h0000;
      end else begin
         if (pc_load_q) pc_in <= pc_q;
         if (push_q) stack_top <= push_addr_q;
      end
   end
endmodule // exec_partner

// ### verilog/cpu_alu_branch_exec.v
// Execution datapath: arithmetic, logic, multiply, jump, call and skip
`include "alu_exec_regs.vh"

// Behaviour
// - Add, add-carry: one cycle, ZCNVSH
// - Word add immediate: two cycles, ZCNVS
// - Word subtract immediate: two cycles, ZCNVS
// - Subtract register or constant: one cycle, ZCNVSH
// - Borrow subtract deducts carry, one cycle
// - Borrow constant subtract deducts carry, one cycle
// - And, or, xor: ZNVS only, one cycle
// - Clear mask ands complement, set ors
// - Probe ands self, value unchanged, ZNVS
// - Products into R1:R0, ZC, two cycles
// - Fractional products shifted left once
// - Relative jump two, call three cycles
// - Pointer jump loads Z, two cycles
// - Pointer call loads Z, three cycles
// - Equal compare skips next instruction
module cpu_alu_branch_exec (
   // Clock, reset, enable
   input wire mclk,
   input wire rst_b,
   input wire clk_en,
   // Decoder request
   input wire op_start,
   input wire [4:0] op_code,
   input wire [7:0] rd_val,
   input wire [7:0] rr_val,
   input wire [7:0] rd_hi_val,
   input wire [7:0] imm_val,
   input wire [11:0] rel_offset,
   input wire [15:0] z_ptr,
   input wire next_is_two_word,
   // Program counter and stack
   input wire [15:0] pc_in,
   output reg [15:0] pc_q,
   output reg pc_load_q,
   output reg push_q,
   output reg [15:0] push_addr_q,
   // Register file write back
   output reg rd_we_q,
   output reg [7:0] rd_res_q,
   output reg rd_hi_we_q,
   output reg [7:0] rd_hi_res_q,
   output reg prod_we_q,
   output reg [15:0] prod_q,
   // Status
   output reg [5:0] flags_q,
   output wire busy,
   output reg done_q
);

   // State codes, one-hot
   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;

   // ==========================================================
   // Combinational result
   reg [8:0] sum9;
   reg [7:0] b_op;
   reg carry_in;
   reg [16:0] w17;
   reg signed [17:0] mul_s;
   reg [15:0] mul_p;
   reg [7:0] res8;
   reg [5:0] fl_d;
   reg is_byte;
   reg is_word;
   reg is_mul;
   reg is_ctl;
   reg [1:0] cyc_d;
   reg [15:0] pc_d;
   reg push_d;
   reg pc_ld_d;
   reg [15:0] ret_d;

   // Whole result and flags worked out in the issue cycle
   always @* begin
      sum9 = 9'h000;
      b_op = 8'h00;
      carry_in = 1'b0;
      w17 = 17'h00000;
      mul_s = 18'sh00000;
      mul_p = 16'h0000;
      res8 = rd_val;
      fl_d = flags_q;
      is_byte = 1'b0;
      is_word = 1'b0;
      is_mul = 1'b0;
      is_ctl = 1'b0;
      cyc_d = `CYC_ONE;
      pc_d = pc_in;
      push_d = 1'b0;
      pc_ld_d = 1'b0;
      ret_d = 16'h0000;
      case (op_code)
         `OP_ADD, `OP_ADD_CARRY: begin
            carry_in = (op_code == `OP_ADD_CARRY) & flags_q[`FLAG_C];
            sum9 = {1'b0, rd_val} + {1'b0, rr_val} + {8'h00, carry_in};
            res8 = sum9[7:0];
            is_byte = 1'b1;
            fl_d[`FLAG_C] = sum9[8];
            fl_d[`FLAG_H] = (rd_val[3] & rr_val[3]) | (rr_val[3] & ~res8[3])
               | (~res8[3] & rd_val[3]);
            fl_d[`FLAG_V] = (rd_val[7] & rr_val[7] & ~res8[7])
               | (~rd_val[7] & ~rr_val[7] & res8[7]);
         end
         `OP_SUB, `OP_CONSTANT_SUBTRACT, `OP_BORROW_SUBTRACT,
         `OP_BORROW_CONST_SUBTRACT: begin
            b_op = (op_code == `OP_SUB || op_code == `OP_BORROW_SUBTRACT) ? rr_val
               : imm_val;
            carry_in = (op_code == `OP_BORROW_SUBTRACT
               || op_code == `OP_BORROW_CONST_SUBTRACT) & flags_q[`FLAG_C];
            sum9 = {1'b0, rd_val} - {1'b0, b_op} - {8'h00, carry_in};
            res8 = sum9[7:0];
            is_byte = 1'b1;
            fl_d[`FLAG_C] = sum9[8];
            fl_d[`FLAG_H] = (~rd_val[3] & b_op[3]) | (b_op[3] & res8[3])
               | (res8[3] & ~rd_val[3]);
            fl_d[`FLAG_V] = (rd_val[7] & ~b_op[7] & ~res8[7])
               | (~rd_val[7] & b_op[7] & res8[7]);
         end
         `OP_AND, `OP_AND_CONST, `OP_OR, `OP_OR_CONST, `OP_EXCLUSIVE_OR,
         `OP_BIT_SET_MASK, `OP_BIT_CLEAR_MASK, `OP_SELF_AND_PROBE: begin
            case (op_code)
               `OP_AND: res8 = rd_val & rr_val;
               `OP_AND_CONST: res8 = rd_val & imm_val;
               `OP_OR: res8 = rd_val | rr_val;
               `OP_OR_CONST, `OP_BIT_SET_MASK: res8 = rd_val | imm_val;
               `OP_EXCLUSIVE_OR: res8 = rd_val ^ rr_val;
               `OP_BIT_CLEAR_MASK: res8 = rd_val & (`BYTE_ALL_ONES - imm_val);
               default: res8 = rd_val & rd_val;
            endcase
            is_byte = 1'b1;
            fl_d[`FLAG_V] = 1'b0;
         end
         // Pair ops: carry is the carry or borrow out of bit 15
         `OP_WORD_IMMEDIATE_ADD, `OP_WORD_IMMEDIATE_SUBTRACT: begin
            if (op_code == `OP_WORD_IMMEDIATE_ADD)
               w17 = {1'b0, rd_hi_val, rd_val} + {9'h000, imm_val};
            else
               w17 = {1'b0, rd_hi_val, rd_val} - {9'h000, imm_val};
            is_word = 1'b1;
            cyc_d = `CYC_TWO;
            fl_d[`FLAG_C] = w17[16];
            fl_d[`FLAG_Z] = (w17[15:0] == 16'h0000);
            fl_d[`FLAG_N] = w17[15];
            fl_d[`FLAG_V] = (op_code == `OP_WORD_IMMEDIATE_ADD) ? (~rd_hi_val[7] & w17[15])
               : (rd_hi_val[7] & ~w17[15]);
            fl_d[`FLAG_S] = fl_d[`FLAG_N] ^ fl_d[`FLAG_V];
         end
         `OP_UNSIGNED_PRODUCT, `OP_SIGNED_PRODUCT, `OP_MIXED_SIGN_PRODUCT,
         `OP_FRACTION_UNSIGNED_PRODUCT, `OP_FRACTION_SIGNED_PRODUCT,
         `OP_FRACTION_MIXED_PRODUCT: begin
            // Sign-extend per variant, then one signed multiply
            case (op_code)
               `OP_SIGNED_PRODUCT, `OP_FRACTION_SIGNED_PRODUCT:
                  mul_s = $signed({rd_val[7], rd_val}) * $signed({rr_val[7], rr_val});
               `OP_MIXED_SIGN_PRODUCT, `OP_FRACTION_MIXED_PRODUCT:
                  mul_s = $signed({rd_val[7], rd_val}) * $signed({1'b0, rr_val});
               default: mul_s = $signed({1'b0, rd_val}) * $signed({1'b0, rr_val});
            endcase
            is_mul = 1'b1;
            cyc_d = `CYC_TWO;
            // Carry keeps the unshifted sign bit; zero looks at what is stored
            if (op_code >= `OP_FRACTION_UNSIGNED_PRODUCT) begin
               mul_p = {mul_s[14:0], 1'b0};
               fl_d[`FLAG_C] = mul_s[15];
            end else begin
               mul_p = mul_s[15:0];
               fl_d[`FLAG_C] = mul_s[15];
            end
            fl_d[`FLAG_Z] = (mul_p == 16'h0000);
         end
         `OP_RELATIVE_JUMP, `OP_RELATIVE_CALL: begin
            is_ctl = 1'b1;
            pc_ld_d = 1'b1;
            pc_d = pc_in + {{4{rel_offset[11]}}, rel_offset} + 16'h0001;
            cyc_d = (op_code == `OP_RELATIVE_CALL) ? `CYC_THREE : `CYC_TWO;
            push_d = (op_code == `OP_RELATIVE_CALL);
            ret_d = pc_in + 16'h0001;
         end
         `OP_POINTER_JUMP, `OP_POINTER_CALL: begin
            is_ctl = 1'b1;
            pc_ld_d = 1'b1;
            pc_d = z_ptr;
            cyc_d = (op_code == `OP_POINTER_CALL) ? `CYC_THREE : `CYC_TWO;
            push_d = (op_code == `OP_POINTER_CALL);
            ret_d = pc_in + 16'h0001;
         end
         // Skip lands two or three words on, by the size of the skipped op
         `OP_COMPARE_SKIP_EQUAL: begin
            is_ctl = 1'b1;
            pc_ld_d = 1'b1;
            if (rd_val == rr_val) begin
               pc_d = pc_in + (next_is_two_word ? 16'h0003 : 16'h0002);
               cyc_d = next_is_two_word ? `CYC_THREE : `CYC_TWO;
            end else begin
               pc_d = pc_in + 16'h0001;
            end
         end
         default: begin
            // Unknown codes just finish, flags and registers left alone
            cyc_d = `CYC_ONE;
         end
      endcase
      // Byte-wide zero and sign
      if (is_byte) begin
         fl_d[`FLAG_Z] = (res8 == 8'h00);
         fl_d[`FLAG_N] = res8[7];
         fl_d[`FLAG_S] = res8[7] ^ fl_d[`FLAG_V];
      end
   end

   // ==========================================================
   // Sequencer
   reg [1:0] state_q;
   reg [1:0] cnt_q;
   reg [15:0] pc_hold_q;
   // Only control ops hand over a new PC; the rest let the decoder step it
   reg ld_hold_q;

   // Busy covers the wait cycles only, so op_start there is refused
   assign busy = state_q[1];

   // Data and flags update in the issue cycle; the wait state holds back the PC load
   // and done so the decoder sees the documented cycle total before the next issue.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         cnt_q <= 2'h0;
         pc_q <= `PC_RESET;
         pc_hold_q <= `PC_RESET;
         ld_hold_q <= 1'b0;
         pc_load_q <= 1'b0;
         push_q <= 1'b0;
         push_addr_q <= 16'h0000;
         rd_we_q <= 1'b0;
         rd_res_q <= 8'h00;
         rd_hi_we_q <= 1'b0;
         rd_hi_res_q <= 8'h00;
         prod_we_q <= 1'b0;
         prod_q <= 16'h0000;
         flags_q <= `FLAGS_RESET;
         done_q <= 1'b0;
      end else if (clk_en) begin
         rd_we_q <= 1'b0;
         rd_hi_we_q <= 1'b0;
         prod_we_q <= 1'b0;
         push_q <= 1'b0;
         pc_load_q <= 1'b0;
         done_q <= 1'b0;
         // Write enables are one-cycle pulses; data holds until the next op
         case (state_q)
            ST_IDLE: begin
               if (op_start) begin
                  rd_res_q <= is_word ? w17[7:0] : res8;
                  rd_hi_res_q <= w17[15:8];
                  rd_we_q <= is_byte | is_word;
                  rd_hi_we_q <= is_word;
                  prod_q <= mul_p;
                  prod_we_q <= is_mul;
                  if (!is_ctl) begin
                     flags_q <= fl_d;
                  end
                  // Return address stacked before the jump lands
                  push_q <= push_d;
                  push_addr_q <= ret_d;
                  pc_hold_q <= pc_d;
                  ld_hold_q <= pc_ld_d;
                  if (cyc_d == `CYC_ONE) begin
                     pc_q <= pc_d;
                     pc_load_q <= pc_ld_d;
                     done_q <= 1'b1;
                  end else begin
                     cnt_q <= cyc_d - 2'h1;
                     state_q <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (cnt_q == 2'h1) begin
                  // Last cycle: a reload of the current PC would repeat the op
                  pc_q <= pc_hold_q;
                  pc_load_q <= ld_hold_q;
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
               cnt_q <= cnt_q - 2'h1;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // cpu_alu_branch_exec
